/* File: src/clock_gen_ctrl_registers.sv */
// Control register slice: status pin options, manual sync, power-down, update strobe, segment list
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module clock_gen_ctrl_registers
    import clock_gen_ctrl_pkg::*;
#(
    parameter int SEG_IDX_W = 5
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic sclk_rise,
    input wire logic [5:0] mon_sel_a,
    input wire logic [5:0] mon_sel_b,
    input wire logic mon_src_a,
    input wire logic mon_src_b,
    input wire logic synth_ref_clk,
    input wire logic synth_pfd_up,
    input wire logic nvm_busy,
    input wire logic divider_align_n,
    input wire logic nvm_update_req,
    input wire logic [SEG_IDX_W-1:0] nvm_seg_idx,
    output logic [7:0] nvm_seg_byte,
    output logic nvm_seg_is_update,
    output logic nvm_seg_is_end,
    output logic monitor_pin_a,
    output logic monitor_pin_b,
    output logic divider_sync_n,
    output logic pd_cleanup_loop,
    output logic pd_synth_loop,
    output logic pd_distribution,
    output logic update_pending
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Segment-window address test, used by both write and read paths
    function automatic logic in_seg(input logic [11:0] a);
        in_seg = (a >= ADDR_SEG_FIRST) && (a <= ADDR_SEG_LAST);
    endfunction

    // Monitor routing for one pin; reserved codes route a constant low
    // Codes below the halved sources come from the outside monitor logic
    function automatic logic mon_route(input logic [5:0] sel, input logic src,
                                       input logic ref_half, input logic pfd_half);
        if (sel == MON_SYNTH_REF_HALF) begin
            mon_route = ref_half;
        end else if (sel == MON_SYNTH_PFD_UP_HALF) begin
            mon_route = pfd_half;
        end else if (sel > MON_SYNTH_PFD_UP_HALF) begin
            mon_route = 1'b0;
        end else begin
            mon_route = src;
        end
    endfunction

    // Opcode test, used for the nvm lookup port
    function automatic logic is_op(input logic [7:0] b, input logic [7:0] op);
        is_op = (b == op);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    // The status and power-down registers each keep a buffer copy that the host sees and an active
    // copy that drives the outputs; reads never show the active copy.

    logic [7:0] status_buf_reg;
    logic [7:0] status_act_reg;
    logic [7:0] pd_buf_reg;
    logic [7:0] pd_act_reg;
    logic update_reg;
    logic update_next;
    logic [7:0] seg_reg [0:SEG_COUNT-1];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;

    // Address decode
    // Offsets outside the segment window never index the array; hit_seg guards them
    wire hit_status = (reg_addr == ADDR_STATUS_SYNC);
    wire hit_pd = (reg_addr == ADDR_POWER_DOWN);
    wire hit_update = (reg_addr == ADDR_UPDATE);
    wire hit_seg = in_seg(reg_addr);
    wire [4:0] seg_off = 5'(reg_addr - ADDR_SEG_FIRST);
    wire update_write = reg_wr & hit_update & reg_wdata[BIT_UPDATE];

    // The nvm path skips the serial edge because a restore runs with no host clock
    // copy on serial edge
    // A pending request copies at a serial clock rise; an nvm update opcode copies directly
    wire do_copy = (update_reg & sclk_rise) | nvm_update_req;

    // Writing zero to the update bit is harmless; it never cancels a request
    // self clearing update
    // A fresh write in the copy cycle keeps the request alive for the next rise
    assign update_next = update_write ? 1'b1 : (do_copy ? 1'b0 : update_reg);

    // reserved bits masked
    // Buffered registers; only defined bits are stored
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_buf_reg <= RESET_STATUS_SYNC;
            pd_buf_reg <= RESET_POWER_DOWN;
            update_reg <= 1'b0;
        end else if (ce) begin
            if (reg_wr && hit_status) begin
                status_buf_reg <= reg_wdata & MASK_STATUS_SYNC;
            end
            if (reg_wr && hit_pd) begin
                pd_buf_reg <= reg_wdata & MASK_POWER_DOWN;
            end
            update_reg <= update_next;
        end
    end

    // active set gated
    // Active copies change only on an update, so writes alone never reach the pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_act_reg <= RESET_STATUS_SYNC;
            pd_act_reg <= RESET_POWER_DOWN;
        end else if (ce && do_copy) begin
            status_act_reg <= status_buf_reg;
            pd_act_reg <= pd_buf_reg;
        end
    end

    // One process per entry keeps each reset value constant and the write
    // decode a single compare against the loop index
    // segment list storage
    genvar gi;
    generate
        for (gi = 0; gi < SEG_COUNT; gi++) begin : g_seg
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    seg_reg[gi] <= SEG_RESET[gi];
                end else if (ce && reg_wr && hit_seg && (seg_off == 5'(gi))) begin
                    seg_reg[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    // Reads return the buffer copies, so a read right after a write confirms it
    // even before any update has been issued
    // Read mux; unmapped addresses answer zero
    always_comb begin
        rdata_next = 8'h00;
        if (hit_status) begin
            rdata_next = status_buf_reg;
        end else if (hit_pd) begin
            rdata_next = pd_buf_reg;
        end else if (hit_update) begin
            rdata_next = {7'h00, update_reg} & MASK_UPDATE;
        end else if (hit_seg) begin
            rdata_next = seg_reg[seg_off];
        end
    end

    // Read data lands one cycle after the strobe
    // Data then holds between reads so a slow front end can pick it up late
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else if (ce) begin
            rvalid_reg <= reg_rd;
            if (reg_rd) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg & ce;
    assign update_pending = update_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Nonvolatile controller lookup

    logic [7:0] seg_byte_reg;
    wire seg_idx_ok = (nvm_seg_idx < SEG_IDX_W'(SEG_COUNT));

    // The controller walks the list one index at a time; one cycle of latency
    // keeps the array read off its own timing path
    // Registered so the controller sees a stable byte; out-of-range reads as end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seg_byte_reg <= OP_END;
        end else if (ce) begin
            seg_byte_reg <= seg_idx_ok ? seg_reg[nvm_seg_idx] : OP_END;
        end
    end

    assign nvm_seg_byte = seg_byte_reg;
    assign nvm_seg_is_update = is_op(seg_byte_reg, OP_UPDATE);
    assign nvm_seg_is_end = is_op(seg_byte_reg, OP_END);

    ////////////////////////////////////////////////////////////////////////////
    // Monitor pins

    logic ref_half;
    logic pfd_half;
    logic [1:0] mon_raw;
    logic [1:0] mon_quarter;
    logic [1:0] mon_div_en;
    logic pin_a_reg;
    logic pin_b_reg;

    // Trade-off: a select change can clip one period of the halved view
    // halved sources
    // Halved views are free-running so switching selects never glitches a counter
    edge_divider #(.CNT_W(1)) u_ref_half (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .sig_in(synth_ref_clk),
        .sig_out(ref_half)
    );

    edge_divider #(.CNT_W(1)) u_pfd_half (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .sig_in(synth_pfd_up),
        .sig_out(pfd_half)
    );

    assign mon_raw[0] = status_act_reg[BIT_BUSY_ON_PIN_A] ? nvm_busy
                      : mon_route(mon_sel_a, mon_src_a, ref_half, pfd_half);
    assign mon_raw[1] = mon_route(mon_sel_b, mon_src_b, ref_half, pfd_half);
    assign mon_div_en[0] = status_act_reg[BIT_DIV4_PIN_A];
    assign mon_div_en[1] = status_act_reg[BIT_DIV4_PIN_B];

    // Limitation: a frozen divided pin may rest high or low
    // pin B divide-by-4
    // pin A divide-by-4
    // A static code gives no edges, so the divided pin just freezes; software avoids that case
    generate
        for (gi = 0; gi < 2; gi++) begin : g_div4
            edge_divider #(.CNT_W(2)) u_quarter (
                .clk_sys(clk_sys),
                .rst(rst),
                .ce(ce),
                .sig_in(mon_raw[gi]),
                .sig_out(mon_quarter[gi])
            );
        end
    endgenerate

    // Pins are registered to keep them glitch free
    // The extra flop costs one cycle of lag on every monitored signal
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_a_reg <= 1'b0;
            pin_b_reg <= 1'b0;
        end else if (ce) begin
            pin_a_reg <= mon_div_en[0] ? mon_quarter[0] : mon_raw[0];
            pin_b_reg <= mon_div_en[1] ? mon_quarter[1] : mon_raw[1];
        end
    end

    assign monitor_pin_a = pin_a_reg;
    assign monitor_pin_b = pin_b_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Sync and power-down outputs

    // Combinational so a low align pin acts at once, with no clock needed
    // manual divider sync
    assign divider_sync_n = divider_align_n & ~status_act_reg[BIT_MANUAL_SYNC];

    // Driven from the active copies only; the buffer side never reaches them
    // section power-down
    assign pd_cleanup_loop = pd_act_reg[BIT_PD_CLEANUP_LOOP];
    assign pd_synth_loop = pd_act_reg[BIT_PD_SYNTH_LOOP];
    assign pd_distribution = pd_act_reg[BIT_PD_DISTRIBUTION];

endmodule // clock_gen_ctrl_registers

/* File: src/clock_gen_ctrl_pkg.sv */
// Shared constants for the clock generator control register slice
package clock_gen_ctrl_pkg;

    // Register addresses on the serial control port
    localparam logic [11:0] ADDR_STATUS_SYNC = 12'h232;
    localparam logic [11:0] ADDR_POWER_DOWN = 12'h233;
    localparam logic [11:0] ADDR_UPDATE = 12'h234;
    localparam logic [11:0] ADDR_SEG_FIRST = 12'ha00;
    localparam logic [11:0] ADDR_SEG_LAST = 12'ha16;
    localparam int SEG_COUNT = 23;

    // Field positions in status_pin_and_sync_control
    localparam int BIT_MANUAL_SYNC = 0;
    localparam int BIT_DIV4_PIN_A = 2;
    localparam int BIT_DIV4_PIN_B = 3;
    localparam int BIT_BUSY_ON_PIN_A = 4;
    localparam logic [7:0] MASK_STATUS_SYNC = 8'h1d;

    // Field positions in section_power_down
    localparam int BIT_PD_DISTRIBUTION = 0;
    localparam int BIT_PD_SYNTH_LOOP = 1;
    localparam int BIT_PD_CLEANUP_LOOP = 2;
    localparam logic [7:0] MASK_POWER_DOWN = 8'h07;

    // Field position in update_all_strobe
    localparam int BIT_UPDATE = 0;
    localparam logic [7:0] MASK_UPDATE = 8'h01;

    // Reset values
    localparam logic [7:0] RESET_STATUS_SYNC = 8'h00;
    localparam logic [7:0] RESET_POWER_DOWN = 8'h07;

    // Monitor select codes
    localparam logic [5:0] MON_SYNTH_REF_HALF = 6'h16;
    localparam logic [5:0] MON_SYNTH_PFD_UP_HALF = 6'h17;
    localparam logic [5:0] MON_LAST_STATIC = 6'h0f;

    // Operation codes held in the segment list
    localparam logic [7:0] OP_UPDATE = 8'h80;
    localparam logic [7:0] OP_END = 8'hff;

    // Segment list reset image: seven entries of byte count, address high,
    // address low, then an update command and the end marker
    localparam logic [7:0] SEG_RESET [0:22] = '{
        8'h03, 8'h00, 8'h00,
        8'h05, 8'h00, 8'h04,
        8'h1f, 8'h00, 8'h10,
        8'h2f, 8'h01, 8'h90,
        8'h04, 8'h02, 8'h30,
        8'h0f, 8'h03, 8'h00,
        8'h07, 8'h04, 8'h00,
        OP_UPDATE, OP_END
    };

endpackage

/* File: src/edge_divider.sv */
// Divides the rising-edge rate of a sampled level by a power of two
`timescale 1ns/1ps

module edge_divider #(
    parameter int CNT_W = 2
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic sig_in,
    output logic sig_out
);

    logic last_reg;
    logic [CNT_W-1:0] cnt_reg;
    wire rise = sig_in & ~last_reg;

    // Count input rising edges; the top count bit is the divided view
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            last_reg <= 1'b0;
            cnt_reg <= '0;
        end else if (ce) begin
            last_reg <= sig_in;
            if (rise) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    assign sig_out = cnt_reg[CNT_W-1];

endmodule // edge_divider

/* File: tb/clock_gen_ctrl_registers_asserts.sv */
// Port-level checks for the control register slice
`timescale 1ns/1ps
module clock_gen_ctrl_registers_asserts
    import clock_gen_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic sclk_rise,
    input wire logic divider_align_n,
    input wire logic nvm_update_req,
    input wire logic [7:0] nvm_seg_byte,
    input wire logic nvm_seg_is_end,
    input wire logic divider_sync_n,
    input wire logic pd_cleanup_loop,
    input wire logic pd_synth_loop,
    input wire logic pd_distribution,
    input wire logic update_pending
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Decodes that the properties share
    wire logic upd_wr = ce && reg_wr && reg_addr == ADDR_UPDATE && reg_wdata[BIT_UPDATE];
    wire logic mapped = (reg_addr >= ADDR_STATUS_SYNC && reg_addr <= ADDR_UPDATE)
        || (reg_addr >= ADDR_SEG_FIRST && reg_addr <= ADDR_SEG_LAST);
    wire logic [2:0] pd_all = {pd_cleanup_loop, pd_synth_loop, pd_distribution};
    sequence s_upd_req;
        ce && reg_wr && reg_addr == ADDR_UPDATE && reg_wdata[BIT_UPDATE];
    endsequence
    sequence s_copy;
        ce && update_pending && sclk_rise && !upd_wr;
    endsequence
    property p_upd_set; s_upd_req |=> update_pending; endproperty
    property p_upd_clear; s_copy |=> !update_pending; endproperty
    property p_pd_hold;
        ce && !nvm_update_req && !(update_pending && sclk_rise) |=> $stable(pd_all);
    endproperty
    property p_pd_reset; $fell(rst) |-> pd_all == 3'h7; endproperty
    property p_align; !divider_align_n |-> !divider_sync_n; endproperty
    property p_rvalid; ce && reg_rd |=> reg_rvalid; endproperty
    property p_unmapped; ce && reg_rd && !mapped |=> reg_rdata == 8'h00; endproperty
    property p_seg_end; nvm_seg_is_end |-> nvm_seg_byte == OP_END; endproperty
    a_upd_set: assert property (p_upd_set) else $error("update bit not set by write");
    a_upd_clear: assert property (p_upd_clear) else $error("update bit not self cleared");
    a_pd_hold: assert property (p_pd_hold) else $error("power-down changed without update");
    a_pd_reset: assert property (@(posedge clk_sys) p_pd_reset) else $error("power-down not one in reset");
    a_align: assert property (p_align) else $error("align pin low but sync released");
    a_rvalid: assert property (p_rvalid) else $error("read valid missing");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_seg_end: assert property (p_seg_end) else $error("end flag on wrong byte");
endmodule // clock_gen_ctrl_registers_asserts

/* File: tb/host_port_model.sv */
// Host model driving the parallel register front end and serial clock edges
`timescale 1ns/1ps
module host_port_model (
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic [11:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic sclk_rise
);
    // Idle bus at time zero
    initial begin
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sclk_rise = 1'b0;
    end
    // Released lines show the inverse so a stale value never looks valid
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // Bounded wait for read valid
    task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        reg_addr = ~a;
        ok = 1'b0;
        d = 8'h00;
        repeat (3) begin
            if (!ok && reg_rvalid === 1'b1) begin
                ok = 1'b1;
                d = reg_rdata;
            end
            if (!ok) @(negedge clk_sys);
        end
    endtask
    task automatic sclk();
        @(negedge clk_sys);
        sclk_rise = 1'b1;
        @(negedge clk_sys);
        sclk_rise = 1'b0;
    endtask
endmodule // host_port_model

/* File: tb/clock_gen_ctrl_registers_tb_top.sv */
// Self-checking testbench for the control register slice
`timescale 1ns/1ps
module clock_gen_ctrl_registers_tb_top;
    import clock_gen_ctrl_pkg::*;
    logic clk_sys, rst, ce, reg_wr, reg_rd, reg_rvalid, sclk_rise, synth_ref_clk, synth_pfd_up;
    logic nvm_busy, divider_align_n, nvm_update_req, is_upd, is_end, pin_a, pin_b, sync_n;
    logic pd_c, pd_s, pd_d, update_pending;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, seg_byte;
    logic [5:0] mon_sel_a, mon_sel_b;
    logic [4:0] seg_idx;
    int err_total = 0;
    int check_count = 0;
    clock_gen_ctrl_registers clock_gen_ctrl_registers_i (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sclk_rise(sclk_rise), .mon_sel_a(mon_sel_a),
        .mon_sel_b(mon_sel_b), .mon_src_a(1'b0), .mon_src_b(1'b0), .synth_ref_clk(synth_ref_clk),
        .synth_pfd_up(synth_pfd_up), .nvm_busy(nvm_busy), .divider_align_n(divider_align_n),
        .nvm_update_req(nvm_update_req), .nvm_seg_idx(seg_idx), .nvm_seg_byte(seg_byte),
        .nvm_seg_is_update(is_upd), .nvm_seg_is_end(is_end), .monitor_pin_a(pin_a), .monitor_pin_b(pin_b),
        .divider_sync_n(sync_n), .pd_cleanup_loop(pd_c), .pd_synth_loop(pd_s), .pd_distribution(pd_d),
        .update_pending(update_pending));
    host_port_model host_port_model_i (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .sclk_rise(sclk_rise));
    // Clock and free-running monitor sources
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        synth_ref_clk <= ~synth_ref_clk;
        synth_pfd_up <= ~synth_pfd_up;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host_port_model_i.rd(a, d, ok);
        if (!ok) chk("read valid", 8'h00, 8'h01);
        chk($sformatf("read %h", a), d, exp);
    endtask
    // Host sets the update bit, then one serial edge performs the copy
    task automatic update();
        host_port_model_i.wr(ADDR_UPDATE, 8'h01);
        host_port_model_i.sclk();
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic toggles(input logic pick_b, output int n);
        logic last;
        repeat (8) @(negedge clk_sys);
        last = pick_b ? pin_b : pin_a;
        n = 0;
        repeat (32) begin
            @(negedge clk_sys);
            if ((pick_b ? pin_b : pin_a) !== last) n++;
            last = pick_b ? pin_b : pin_a;
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_update();
        chk("pd reset", {5'h00, pd_c, pd_s, pd_d}, RESET_POWER_DOWN);
        rchk(ADDR_STATUS_SYNC, 8'h00);
        host_port_model_i.wr(ADDR_POWER_DOWN, 8'h00);
        rchk(ADDR_POWER_DOWN, 8'h00);
        chk("pd before update", {5'h00, pd_c, pd_s, pd_d}, 8'h07);
        host_port_model_i.wr(ADDR_UPDATE, 8'hff);
        rchk(ADDR_UPDATE, 8'h01);
        host_port_model_i.sclk();
        repeat (2) @(negedge clk_sys);
        chk("pd after update", {5'h00, pd_c, pd_s, pd_d}, 8'h00);
        chk("update bit", {7'h00, update_pending}, 8'h00);
        host_port_model_i.wr(ADDR_POWER_DOWN, 8'hff);
        rchk(ADDR_POWER_DOWN, 8'h07);
        rchk(12'h240, 8'h00);
        host_port_model_i.wr(ADDR_POWER_DOWN, 8'h05);
        nvm_update_req = 1'b1;
        @(negedge clk_sys);
        nvm_update_req = 1'b0;
        @(negedge clk_sys);
        chk("pd bit order", {5'h00, pd_c, pd_s, pd_d}, 8'h05);
        ce = 1'b0;
        host_port_model_i.wr(ADDR_POWER_DOWN, 8'h02);
        ce = 1'b1;
        rchk(ADDR_POWER_DOWN, 8'h05);
    endtask
    task automatic t_sync();
        host_port_model_i.wr(ADDR_STATUS_SYNC, 8'h03);
        rchk(ADDR_STATUS_SYNC, 8'h01);
        update();
        chk("manual sync", {7'h00, sync_n}, 8'h00);
        host_port_model_i.wr(ADDR_STATUS_SYNC, 8'h00);
        update();
        chk("sync release", {7'h00, sync_n}, 8'h01);
        divider_align_n = 1'b0;
        @(negedge clk_sys);
        chk("align pin sync", {7'h00, sync_n}, 8'h00);
        divider_align_n = 1'b1;
    endtask
    task automatic t_segments();
        for (int i = 0; i < SEG_COUNT; i++) begin
            seg_idx = 5'(i);
            repeat (2) @(negedge clk_sys);
            chk("segment byte", seg_byte, SEG_RESET[i]);
            chk("opcode flags", {6'h00, is_upd, is_end}, {6'h00, SEG_RESET[i] == OP_UPDATE, SEG_RESET[i] == OP_END});
        end
        rchk(ADDR_SEG_LAST, OP_END);
        host_port_model_i.wr(12'ha05, 8'h5a);
        rchk(12'ha05, 8'h5a);
    endtask
    task automatic t_monitor();
        int n;
        mon_sel_a = MON_SYNTH_REF_HALF;
        mon_sel_b = MON_SYNTH_PFD_UP_HALF;
        toggles(1'b0, n);
        chk("ref half toggles", 8'(n), 8'h10);
        toggles(1'b1, n);
        chk("pfd half toggles", 8'(n), 8'h10);
        host_port_model_i.wr(ADDR_STATUS_SYNC, 8'h0c);
        update();
        toggles(1'b0, n);
        chk("pin a div4 toggles", 8'(n), 8'h04);
        toggles(1'b1, n);
        chk("pin b div4 toggles", 8'(n), 8'h04);
        mon_sel_a = 6'h18;
        toggles(1'b0, n);
        chk("reserved code toggles", 8'(n), 8'h00);
        host_port_model_i.wr(ADDR_STATUS_SYNC, 8'h10);
        update();
        mon_sel_a = 6'h00;
        nvm_busy = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("busy on pin a", {7'h00, pin_a}, 8'h01);
        nvm_busy = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("idle on pin a", {7'h00, pin_a}, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        summarize();
    end
    initial begin
        {rst, ce, synth_ref_clk, synth_pfd_up, nvm_busy, divider_align_n, nvm_update_req} = 7'h62;
        {mon_sel_a, mon_sel_b, seg_idx} = 17'h00000;
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        t_update();
        t_sync();
        t_segments();
        t_monitor();
        summarize();
    end
endmodule // clock_gen_ctrl_registers_tb_top
bind clock_gen_ctrl_registers clock_gen_ctrl_registers_asserts clock_gen_ctrl_registers_asserts_i (.clk_sys,
    .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .sclk_rise, .divider_align_n,
    .nvm_update_req, .nvm_seg_byte, .nvm_seg_is_end, .divider_sync_n, .pd_cleanup_loop, .pd_synth_loop,
    .pd_distribution, .update_pending);
